// ### hdl/serial_break_send_detect.sv
// Break send and detect logic of an asynchronous serial transceiver
`include "serial_break_params.svh"
module serial_break_send_detect
	import serial_break_pkg::*;
(
	input  wire logic       ref_clk,
	input  wire logic       sys_rst,
	input  wire logic       ce,
	input  wire logic [2:0] addr,
	input  wire logic [7:0] wdata,
	input  wire logic       wr,
	input  wire logic       rd,
	output logic      [7:0] rdata,
	output logic            tx_out,
	output logic            tx_oe,
	input  wire logic       serial_receive_line,
	output logic            rx_pin_owned
);
	// ----------------------------------------------------------------
	// Declarations
	// ----------------------------------------------------------------
	logic       transmit_enable_bit;
	logic       send_break_req;
	logic       rx_en;
	logic       wake_en;
	logic       auto_baud_enable;
	logic [7:0] baud_div;
	logic       brk_launched;
	logic       rx_complete_flag;
	logic       framing_error_flag;
	logic [7:0] receive_holding_reg;
	tx_state_e  tx_state;
	logic [7:0] tx_sh;
	logic [3:0] tx_cnt;
	logic       tx_brk;
	logic       tx_line;
	rx_state_e  rx_state;
	logic       rx_s1;
	logic       rx_s2;
	logic       rx_prev;
	logic [7:0] rx_sh;
	logic [2:0] rx_cnt;
	logic [7:0] abd_cnt;
	logic       fifo_in_ready;
	logic       fifo_out_valid;
	logic [8:0] fifo_out;
	logic       tx_tick;
	logic       rx_tick;

	// ----------------------------------------------------------------
	// Register decode
	// ----------------------------------------------------------------
	wire wr_ctl = ce & wr & (addr == `REG_TX_STATUS_CONTROL);
	wire wr_tx  = ce & wr & (addr == `REG_TX_HOLDING);
	wire wr_bd  = ce & wr & (addr == `REG_BAUD);
	wire rd_rx  = ce & rd & (addr == `REG_RX_HOLDING);
	wire shift_reg_empty      = (tx_state == TX_IDLE);
	wire tx_buffer_empty_flag = fifo_in_ready;
	wire [7:0] ctl_val = {3'h0, auto_baud_enable, wake_en, rx_en,
		send_break_req, transmit_enable_bit};
	wire [7:0] st_val = {4'h0, framing_error_flag, rx_complete_flag,
		tx_buffer_empty_flag, shift_reg_empty};
	wire [7:0] rd_mux =
		(addr == `REG_TX_STATUS_CONTROL) ? ctl_val :
		(addr == `REG_STATUS)            ? st_val :
		(addr == `REG_RX_HOLDING)        ? receive_holding_reg :
		(addr == `REG_BAUD)              ? baud_div : 8'h00;

	// ----------------------------------------------------------------
	// Transmit path decode
	// ----------------------------------------------------------------
	// Only the first write after arming is a break; later ones queue
	wire launch = wr_tx & fifo_in_ready & transmit_enable_bit
		& send_break_req & ~brk_launched;
	wire [8:0] fifo_in = launch ? {1'b1, 8'h00} : {1'b0, wdata};
	wire stop_end   = (tx_state == TX_STOP) & tx_tick;
	wire pop = ce & fifo_out_valid & transmit_enable_bit
		& (shift_reg_empty | stop_end);
	wire break_done = stop_end & tx_brk;
	wire [3:0] tx_last = tx_brk ? `BREAK_LAST : `DATA_LAST;

	// ----------------------------------------------------------------
	// Receive path decode
	// ----------------------------------------------------------------
	wire rx_fall   = rx_prev & ~rx_s2;
	wire rx_rise   = ~rx_prev & rx_s2;
	wire rx_done   = (rx_state == RX_STOP) & rx_tick;
	wire wake_done = (rx_state == RX_WAKE_RISE) & rx_rise & ce;
	wire abd_done  = (rx_state == RX_AUTO_BAUD) & rx_rise & ce;
	wire rx_restart = ce & (((rx_state == RX_IDLE) & rx_en & ~wake_en
		& ~auto_baud_enable & rx_fall) | abd_done);

	// ----------------------------------------------------------------
	// Sub-blocks
	// ----------------------------------------------------------------
	tx_fifo #(
		.WIDTH(`TX_FIFO_WIDTH),
		.DEPTH(`TX_FIFO_DEPTH)
	) u_fifo (
		.ref_clk  (ref_clk),
		.sys_rst  (sys_rst),
		.ce       (ce),
		.in_valid (wr_tx),
		.in_ready (fifo_in_ready),
		.in_data  (fifo_in),
		.out_valid(fifo_out_valid),
		.out_ready(pop),
		.out_data (fifo_out)
	);

	baud_tick u_tx_baud (
		.ref_clk(ref_clk),
		.sys_rst(sys_rst),
		.ce     (ce),
		.restart(pop),
		.half   (1'b0),
		.divisor(baud_div),
		.tick   (tx_tick)
	);

	// Receiver restarts at half a bit to sample mid-cell
	baud_tick u_rx_baud (
		.ref_clk(ref_clk),
		.sys_rst(sys_rst),
		.ce     (ce),
		.restart(rx_restart),
		.half   (1'b1),
		.divisor(baud_div),
		.tick   (rx_tick)
	);

	// ----------------------------------------------------------------
	// Control register; hardware clears yield to a software write
	// ----------------------------------------------------------------
	always_ff @(posedge ref_clk) begin
		if (sys_rst) begin
			transmit_enable_bit <= 1'b0;
			send_break_req      <= 1'b0;
			rx_en               <= 1'b0;
			wake_en             <= 1'b0;
			auto_baud_enable    <= 1'b0;
		end else if (wr_ctl) begin
			transmit_enable_bit <= wdata[`CTL_TX_EN];
			send_break_req      <= wdata[`CTL_SEND_BREAK];
			rx_en               <= wdata[`CTL_RX_EN];
			wake_en             <= wdata[`CTL_WAKE_EN];
			auto_baud_enable    <= wdata[`CTL_AUTO_BAUD];
		end else if (ce) begin
			if (break_done)
				send_break_req <= 1'b0;
			if (wake_done)
				wake_en <= 1'b0;
			if (abd_done)
				auto_baud_enable <= 1'b0;
		end
	end

	// Baud divisor, loaded by software or by the auto-baud count
	always_ff @(posedge ref_clk) begin
		if (sys_rst)
			baud_div <= `BAUD_DIV_RST;
		else if (wr_bd)
			baud_div <= wdata;
		else if (abd_done)
			baud_div <= abd_cnt;
	end

	// Read data stands only in the cycle after the strobe
	always_ff @(posedge ref_clk) begin
		if (sys_rst)
			rdata <= 8'h00;
		else if (ce)
			rdata <= (rd ? rd_mux : 8'h00);
	end

	// Break arming: one launch per send-break request
	always_ff @(posedge ref_clk) begin
		if (sys_rst)
			brk_launched <= 1'b0;
		else if (ce) begin
			if (launch)
				brk_launched <= 1'b1;
			else if (break_done | ~transmit_enable_bit)
				brk_launched <= 1'b0;
		end
	end

	// ----------------------------------------------------------------
	// Transmit shifter
	// ----------------------------------------------------------------
	always_ff @(posedge ref_clk) begin
		if (sys_rst) begin
			tx_state <= TX_IDLE;
			tx_sh    <= 8'h00;
			tx_cnt   <= 4'h0;
			tx_brk   <= 1'b0;
			tx_line  <= 1'b1;
		end else if (ce) begin
			if (~transmit_enable_bit) begin
				tx_state <= TX_IDLE;
				tx_line  <= 1'b1;
			end else if (pop) begin
				tx_state <= TX_START;
				tx_sh    <= fifo_out[7:0];
				tx_brk   <= fifo_out[8];
				tx_cnt   <= 4'h0;
				tx_line  <= 1'b0;
			end else if (tx_tick) begin
				case (tx_state)
				TX_START: begin
					tx_state <= TX_DATA;
					tx_line  <= tx_brk ? 1'b0 : tx_sh[0];
				end
				TX_DATA: begin
					if (tx_cnt == tx_last) begin
						tx_state <= TX_STOP;
						tx_line  <= 1'b1;
					end else begin
						tx_cnt  <= tx_cnt + 4'h1;
						tx_sh   <= {1'b0, tx_sh[7:1]};
						tx_line <= tx_brk ? 1'b0 : tx_sh[1];
					end
				end
				TX_STOP: tx_state <= TX_IDLE;
				default: tx_state <= TX_IDLE;
				endcase
			end
		end
	end

	// Pin ownership follows the section enables
	always_ff @(posedge ref_clk) begin
		if (sys_rst) begin
			tx_out       <= 1'b1;
			tx_oe        <= 1'b0;
			rx_pin_owned <= 1'b0;
		end else if (ce) begin
			tx_out       <= tx_line | ~transmit_enable_bit; // Idle on abort
			tx_oe        <= transmit_enable_bit;
			rx_pin_owned <= rx_en;
		end
	end

	// ----------------------------------------------------------------
	// Receive line synchroniser
	// ----------------------------------------------------------------
	always_ff @(posedge ref_clk) begin
		if (sys_rst) begin
			rx_s1   <= 1'b1;
			rx_s2   <= 1'b1;
			rx_prev <= 1'b1;
		end else if (ce) begin
			rx_s1   <= serial_receive_line;
			rx_s2   <= rx_s1;
			rx_prev <= rx_s2;
		end
	end

	// ----------------------------------------------------------------
	// Receive state machine
	// ----------------------------------------------------------------
	always_ff @(posedge ref_clk) begin
		if (sys_rst) begin
			rx_state <= RX_IDLE;
			rx_sh    <= 8'h00;
			rx_cnt   <= 3'h0;
			abd_cnt  <= 8'h00;
		end else if (ce) begin
			if (~rx_en)
				rx_state <= RX_IDLE;
			else begin
				case (rx_state)
				RX_IDLE: begin
					if (wake_en)
						rx_state <= RX_WAKE_FALL;
					else if (rx_fall & auto_baud_enable) begin
						rx_state <= RX_AUTO_BAUD;
						abd_cnt  <= 8'h00;
					end else if (rx_fall)
						rx_state <= RX_START;
				end
				RX_WAKE_FALL: if (rx_fall) rx_state <= RX_WAKE_RISE;
				RX_WAKE_RISE: if (rx_rise) rx_state <= RX_IDLE;
				RX_AUTO_BAUD: begin
					// Start bit width sets the divisor; saturates
					if (abd_done) begin
						rx_state <= RX_DATA;
						rx_cnt   <= 3'h0;
					end else if (abd_cnt != `BAUD_DIV_MAX)
						abd_cnt <= abd_cnt + 8'h01;
				end
				RX_START: if (rx_tick) begin
					rx_state <= rx_s2 ? RX_IDLE : RX_DATA;
					rx_cnt   <= 3'h0;
				end
				RX_DATA: if (rx_tick) begin
					rx_sh  <= {rx_s2, rx_sh[7:1]};
					rx_cnt <= rx_cnt + 3'h1;
					if (rx_cnt == 3'(`DATA_LAST))
						rx_state <= RX_STOP;
				end
				RX_STOP: if (rx_tick)
					rx_state <= rx_s2 ? RX_IDLE : RX_WAIT_HIGH;
				RX_WAIT_HIGH: if (rx_s2) rx_state <= RX_IDLE;
				default: rx_state <= RX_IDLE;
				endcase
			end
		end
	end

	// Received byte and flags; a new event wins over the read clear
	always_ff @(posedge ref_clk) begin
		if (sys_rst) begin
			receive_holding_reg <= 8'h00;
			rx_complete_flag    <= 1'b0;
			framing_error_flag  <= 1'b0;
		end else if (rx_done) begin
			receive_holding_reg <= rx_sh;
			rx_complete_flag    <= 1'b1;
			framing_error_flag  <= ~rx_s2;
		end else if (wake_done)
			rx_complete_flag <= 1'b1;
		else if (rd_rx) begin
			rx_complete_flag   <= 1'b0;
			framing_error_flag <= 1'b0;
		end
	end

	// ----------------------------------------------------------------
	// Assertions
	// ----------------------------------------------------------------
	break_body_low_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
		(tx_state == TX_DATA) && tx_brk |-> !tx_line)
		else $error("break body bit not low");
	break_launch_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
		launch |=> brk_launched && fifo_out_valid)
		else $error("break write did not launch");
	break_data_zero_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
		pop && fifo_out[8] |-> fifo_out[7:0] == 8'h00)
		else $error("break entry carries data");
	break_self_clear_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
		ce && break_done && !wr_ctl |=> !send_break_req)
		else $error("send break not cleared");
	preload_queue_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
		wr_tx && fifo_in_ready && brk_launched |=> fifo_out_valid)
		else $error("byte during break lost");
	busy_shown_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
		pop && transmit_enable_bit |=> !shift_reg_empty)
		else $error("shift empty during transfer");
	buffer_flag_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
		!tx_buffer_empty_flag && !pop |=> !tx_buffer_empty_flag)
		else $error("buffer flag rose with no drain");
	break_rx_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
		rx_done && rx_sh == 8'h00 && !rx_s2 |=>
		rx_complete_flag && framing_error_flag && receive_holding_reg == 8'h00)
		else $error("break not reported");
	wake_flag_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
		wake_done && !wr_ctl |=> rx_complete_flag && !wake_en)
		else $error("wake event not flagged");
	pin_release_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
		ce && !transmit_enable_bit |=> !tx_oe && tx_out)
		else $error("transmit pin not released");
	framing_error_flag_hold_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
		framing_error_flag && !rd_rx && !rx_done |=> framing_error_flag)
		else $error("framing error dropped early");
	no_gap_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
		stop_end && fifo_out_valid && transmit_enable_bit |=>
		tx_state == TX_START && !tx_line)
		else $error("gap after break");

	break_sent_c: cover property (@(posedge ref_clk) disable iff (sys_rst)
		break_done ##1 tx_state == TX_START);
	break_seen_c: cover property (@(posedge ref_clk) disable iff (sys_rst)
		rx_done && !rx_s2 && rx_sh == 8'h00);
	wake_seen_c: cover property (@(posedge ref_clk) disable iff (sys_rst)
		wake_done);
	auto_baud_c: cover property (@(posedge ref_clk) disable iff (sys_rst)
		abd_done);
endmodule // serial_break_send_detect

// ### hdl/serial_break_params.svh
// Register offsets, bit positions, frame counts and reset values
`ifndef SERIAL_BREAK_PARAMS_SVH
`define SERIAL_BREAK_PARAMS_SVH

// ----------------------------------------------------------------
// Register offsets (3-bit address)
// ----------------------------------------------------------------
`define REG_TX_STATUS_CONTROL 3'h0
`define REG_STATUS            3'h1
`define REG_TX_HOLDING        3'h2
`define REG_RX_HOLDING        3'h3
`define REG_BAUD              3'h4

// ----------------------------------------------------------------
// Control bit positions
// ----------------------------------------------------------------
`define CTL_TX_EN      0
`define CTL_SEND_BREAK 1
`define CTL_RX_EN      2
`define CTL_WAKE_EN    3
`define CTL_AUTO_BAUD  4

// ----------------------------------------------------------------
// Status bit positions
// ----------------------------------------------------------------
`define ST_SHIFT_EMPTY 0
`define ST_TX_BUF_EMPTY 1
`define ST_RX_COMPLETE 2
`define ST_FRAMING_ERR 3

// ----------------------------------------------------------------
// Frame shape and reset values
// ----------------------------------------------------------------
`define DATA_LAST      4'h7
`define BREAK_LAST     4'hb
`define BAUD_DIV_RST   8'h0f
`define BAUD_DIV_MAX   8'hff
`define TX_FIFO_DEPTH  8
`define TX_FIFO_WIDTH  9

`endif

// ### hdl/serial_break_pkg.sv
// Types shared by the break send and detect logic
package serial_break_pkg;

	typedef enum logic [1:0] {
		TX_IDLE, TX_START, TX_DATA, TX_STOP
	} tx_state_e;

	typedef enum logic [2:0] {
		RX_IDLE, RX_START, RX_DATA, RX_STOP, RX_WAIT_HIGH,
		RX_WAKE_FALL, RX_WAKE_RISE, RX_AUTO_BAUD
	} rx_state_e;

endpackage

// ### hdl/tx_fifo.sv
// Parameterised synchronous FIFO with valid and ready on both sides
module tx_fifo #(
	parameter int WIDTH = 9,
	parameter int DEPTH = 8
) (
	input  wire logic             ref_clk,
	input  wire logic             sys_rst,
	input  wire logic             ce,
	input  wire logic             in_valid,
	output logic                  in_ready,
	input  wire logic [WIDTH-1:0] in_data,
	output logic                  out_valid,
	input  wire logic             out_ready,
	output logic      [WIDTH-1:0] out_data
);
	localparam int PW = $clog2(DEPTH);

	logic [WIDTH-1:0] mem [DEPTH];
	logic [PW-1:0]    wr_ptr;
	logic [PW-1:0]    rd_ptr;
	logic [PW:0]      count;

	// ----------------------------------------------------------------
	// Handshake decode
	// ----------------------------------------------------------------
	wire push = in_valid & in_ready & ce;
	wire pop  = out_valid & out_ready & ce;
	assign in_ready  = (count != (PW+1)'(DEPTH));
	assign out_valid = (count != '0);
	assign out_data  = mem[rd_ptr];

	// Storage has no reset; only the pointers and count carry state
	always_ff @(posedge ref_clk) begin
		if (push)
			mem[wr_ptr] <= in_data;
	end

	// Pointers wrap; depth is a power of two
	always_ff @(posedge ref_clk) begin
		if (sys_rst) begin
			wr_ptr <= '0;
			rd_ptr <= '0;
			count  <= '0;
		end else begin
			if (push)
				wr_ptr <= wr_ptr + 1'b1;
			if (pop)
				rd_ptr <= rd_ptr + 1'b1;
			count <= count + (PW+1)'(push) - (PW+1)'(pop);
		end
	end
endmodule // tx_fifo

// ### hdl/baud_tick.sv
// Bit-period tick generator, restartable at a full or half period
module baud_tick (
	input  wire logic       ref_clk,
	input  wire logic       sys_rst,
	input  wire logic       ce,
	input  wire logic       restart,
	input  wire logic       half,
	input  wire logic [7:0] divisor,
	output logic            tick
);
	logic [7:0] count;

	// Bit period is divisor+1 cycles; the tick ignores restart, since a
	// restart fed by this tick would otherwise loop back on itself
	assign tick = ce & (count == 8'h00);

	always_ff @(posedge ref_clk) begin
		if (sys_rst)
			count <= 8'h00;
		else if (ce) begin
			if (restart)
				count <= half ? {1'b0, divisor[7:1]} : divisor;
			else if (count == 8'h00)
				count <= divisor;
			else
				count <= count - 8'h01;
		end
	end
endmodule // baud_tick

// ### testbench/serial_node.sv
// Remote bus node model: drives the receive line, samples the transmit line
module serial_node (
	input  wire logic ref_clk,
	input  wire logic tx_line,
	output logic      rx_line
);
	timeunit 1ns;
	timeprecision 100ps;

	// ----
	// Line driver
	// ----
	// Idle and released level is high, as the bus has a pull-up
	initial rx_line = 1'b1;

	// Send n bits LSB first, each clks cycles long, then release the line
	task automatic send_bits(input logic [31:0] bits, input int n,
		input int clks);
		for (int i = 0; i < n; i++) begin
			@(posedge ref_clk);
			rx_line <= bits[i];
			repeat (clks - 1) @(posedge ref_clk);
		end
		@(posedge ref_clk);
		rx_line <= 1'b1;
	endtask

	// One 8N1 character; a slow node is a larger clks
	task automatic send_byte(input logic [7:0] b, input int clks);
		send_bits({22'h0, 1'b1, b, 1'b0}, 10, clks);
	endtask

	// Wait for a start edge, then sample n bits at mid-bit without resync,
	// so any idle gap between characters shows up as a wrong bit
	task automatic get_bits(output logic [23:0] got, input int n,
		input int clks);
		int w;
		got = '0;
		w = 0;
		while (tx_line !== 1'b0 && w < 4000) begin
			@(negedge ref_clk);
			w++;
		end
		repeat (clks / 2) @(negedge ref_clk);
		for (int i = 0; i < n; i++) begin
			if (i > 0) repeat (clks) @(negedge ref_clk);
			got[i] = tx_line;
		end
	endtask
endmodule // serial_node

// ### testbench/tb.sv
// Self-checking bench for the break send and detect block
`include "serial_break_params.svh"
module tb;
	timeunit 1ns;
	timeprecision 100ps;

	logic        ref_clk = 1'b0;
	logic        sys_rst = 1'b1;
	logic        ce      = 1'b1;
	logic [2:0]  addr    = 3'h0;
	logic [7:0]  wdata   = 8'h00;
	logic        wr      = 1'b0;
	logic        rd      = 1'b0;
	logic [7:0]  rdata;
	logic        tx_out;
	logic        tx_oe;
	logic        tx_wire;
	logic        rx_line;
	logic        rx_pin_owned;
	int          bad_count = 0;
	int          n_tests   = 0;
	int          cycles    = 0;
	logic [7:0]  v;
	logic [23:0] g;

	// 25 MHz
	always #20 ref_clk = ~ref_clk;

	// Released transmit pin is pulled high
	assign tx_wire = tx_oe ? tx_out : 1'b1;

	serial_break_send_detect dut (
		.ref_clk             (ref_clk),
		.sys_rst             (sys_rst),
		.ce                  (ce),
		.addr                (addr),
		.wdata               (wdata),
		.wr                  (wr),
		.rd                  (rd),
		.rdata               (rdata),
		.tx_out              (tx_out),
		.tx_oe               (tx_oe),
		.serial_receive_line (rx_line),
		.rx_pin_owned        (rx_pin_owned)
	);

	serial_node node (
		.ref_clk (ref_clk),
		.tx_line (tx_wire),
		.rx_line (rx_line)
	);

	// ----
	// Bus tasks and checks
	// ----
	task automatic wr_reg(input logic [2:0] a, input logic [7:0] d);
		@(posedge ref_clk);
		addr  <= a;
		wdata <= d;
		wr    <= 1'b1;
		@(posedge ref_clk);
		wr    <= 1'b0;
	endtask

	// Read data stand only in the cycle after the strobe
	task automatic rd_reg(input logic [2:0] a, output logic [7:0] d);
		@(posedge ref_clk);
		addr <= a;
		rd   <= 1'b1;
		@(posedge ref_clk);
		rd   <= 1'b0;
		@(negedge ref_clk);
		d = rdata;
	endtask

	task automatic chk(input logic [23:0] got, input logic [23:0] exp);
		n_tests++;
		if (got !== exp) begin
			bad_count++;
			$display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	task automatic rchk(input logic [2:0] a, input logic [7:0] exp);
		logic [7:0] d;
		rd_reg(a, d);
		chk({16'h0, d}, {16'h0, exp});
	endtask

	// Bounded poll until the shifter reports empty
	task automatic wait_idle();
		logic [7:0] d;
		int k;
		d = 8'h00;
		k = 0;
		while (d[`ST_SHIFT_EMPTY] !== 1'b1 && k < 400) begin
			rd_reg(`REG_STATUS, d);
			k++;
		end
	endtask

	task automatic done(input string name);
		$display("test %s finished", name);
	endtask

	task automatic end_sim();
		$display("comparisons %0d mismatches %0d", n_tests, bad_count);
		if (bad_count == 0 && n_tests > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask

	// Hang guard, far above the few thousand cycles the tests need
	always @(posedge ref_clk) begin
		cycles <= cycles + 1;
		if (cycles == 30000) begin
			bad_count++;
			end_sim();
		end
	end

	// ----
	// Test sequence
	// ----
	initial begin
		repeat (16) @(posedge ref_clk);
		sys_rst <= 1'b0;
		rchk(`REG_TX_STATUS_CONTROL, 8'h00);
		rchk(`REG_STATUS, 8'h03);
		rchk(`REG_BAUD, 8'h0f);
		rchk(3'h7, 8'h00);
		chk({22'h0, tx_oe, rx_pin_owned}, 24'h0);
		done("reset");
		// Break header: capture runs beside the writes
		fork
			node.get_bits(g, 24, 16);
			begin
				wr_reg(`REG_TX_STATUS_CONTROL, 8'h03);
				wr_reg(`REG_TX_HOLDING, 8'ha7);
				wr_reg(`REG_TX_HOLDING, 8'h55);
				rchk(`REG_STATUS, 8'h02);
				rchk(`REG_TX_STATUS_CONTROL, 8'h03);
				chk({23'h0, tx_oe}, 24'h1);
			end
		join
		chk(g, {1'b1, 8'h55, 2'b01, 13'h0000});
		wait_idle();
		rchk(`REG_TX_STATUS_CONTROL, 8'h01);
		rchk(`REG_STATUS, 8'h03);
		done("break_header");
		wr_reg(`REG_TX_STATUS_CONTROL, 8'h04);
		repeat (2) @(negedge ref_clk);
		chk({22'h0, tx_oe, rx_pin_owned}, 24'h1);
		done("pin_release");
		wr_reg(`REG_BAUD, 8'h0f);
		node.send_bits(32'h0, 13, 16);
		repeat (4) @(posedge ref_clk);
		rchk(`REG_STATUS, 8'h0f);
		rchk(`REG_STATUS, 8'h0f);
		rchk(`REG_RX_HOLDING, 8'h00);
		rchk(`REG_STATUS, 8'h03);
		node.send_byte(8'ha5, 16);
		repeat (4) @(posedge ref_clk);
		rchk(`REG_STATUS, 8'h07);
		rchk(`REG_RX_HOLDING, 8'ha5);
		done("break_receive");
		wr_reg(`REG_TX_STATUS_CONTROL, 8'h0c);
		node.send_bits(32'h0, 13, 16);
		repeat (4) @(posedge ref_clk);
		rd_reg(`REG_STATUS, v);
		chk({16'h0, v & 8'h04}, 24'h4);
		rchk(`REG_TX_STATUS_CONTROL, 8'h04);
		rd_reg(`REG_RX_HOLDING, v);
		node.send_byte(8'h3c, 16);
		repeat (4) @(posedge ref_clk);
		rchk(`REG_STATUS, 8'h07);
		rchk(`REG_RX_HOLDING, 8'h3c);
		done("wake");
		// Shifter plus eight queued; the tenth write must be dropped
		wr_reg(`REG_TX_STATUS_CONTROL, 8'h01);
		fork
			for (int i = 0; i < 9; i++) begin
				node.get_bits(g, 10, 16);
				chk(g, {14'h0, 1'b1, 8'h10 + 8'(i), 1'b0});
			end
			begin
				for (int i = 0; i < 10; i++)
					wr_reg(`REG_TX_HOLDING, 8'h10 + 8'(i));
				rchk(`REG_STATUS, 8'h00);
			end
		join
		repeat (40) @(posedge ref_clk);
		rchk(`REG_STATUS, 8'h03);
		done("fifo_full");
		// Frozen clock enable: a write in that cycle must not land
		@(posedge ref_clk);
		ce <= 1'b0;
		wr_reg(`REG_BAUD, 8'h33);
		ce <= 1'b1;
		rchk(`REG_BAUD, 8'h0f);
		done("clock_enable");
		wr_reg(`REG_TX_STATUS_CONTROL, 8'h14);
		node.send_byte(8'hc3, 24);
		repeat (4) @(posedge ref_clk);
		rchk(`REG_RX_HOLDING, 8'hc3);
		rchk(`REG_TX_STATUS_CONTROL, 8'h04);
		rd_reg(`REG_BAUD, v);
		chk({23'h0, v >= 8'h16 && v <= 8'h19}, 24'h1);
		done("auto_baud");
		end_sim();
	end
endmodule // tb
